//--- core/adcseq_core.sv
// Conversion sequencer for the 8-channel, 8-bit SAR converter
// What this block does
// - Control write starts conversion unless prescaler zero
// - Sequence and power-up begin with write cycle
// - Sample asserts first falling edge, two cycles
// - Single mode: complete powers converter down
// - Continuous mode: deselect one cycle, then resample
// - Result register updated only after load phase
// - Converter clock is oscillator divided by prescaler
// - Twelve cycles: reset, 2 sample, 8 convert, load
// - Result register is read-only to processor
// - Halt/idle powers down; restart conversion afterwards
// - Control bits: channel 7:5, mode 4:3, prescaler 2:0
// - Mode codes: single/continuous, single-ended/differential
// - Prescaler codes divide 2,4,8,12,24,16,32
// - Channel selects input; differential pairs neighbour
`timescale 1ns/1ps
`include "adcseq_regs.svh"

// ------------------------------------------------------------
// Design notes
// ------------------------------------------------------------
// Converter clock is a divider level, never a second clock net
// Ratio counts oscillator cycles per half period of that level
// Every phase step rides on the falling-level enable alone
// A starting write forces the level high, so write end is never a fall
// Comparator is read unsynchronised: it is timed off this clock,
// and two more flops would eat the fastest ratio's settle time
// Limitation: after a single result the level keeps toggling
// with power low; only prescaler zero or halt stops it

module adcseq_core
    import adcseq_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ctrl_wr,
    input wire logic [7:0] i_ctrl_wdata,
    input wire logic i_halt_idle,
    input wire logic i_sar_cmp,
    output logic [7:0] o_ctrl_rdata,
    output logic [7:0] o_conversion_result,
    output logic o_adc_power,
    output logic o_adc_clk,
    output logic o_adc_select,
    output logic o_sample,
    output logic o_load,
    output logic [2:0] o_pos_chan,
    output logic [2:0] o_neg_chan,
    output logic o_neg_ground,
    output logic [7:0] o_sar_code
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Divider ratio per prescaler code, zero means clock stopped
    function automatic logic [4:0] adcseq_ratio(input logic [2:0] code);
        unique case (code)
            3'h0: adcseq_ratio = 5'h00;
            3'h1: adcseq_ratio = 5'h01;
            3'h2: adcseq_ratio = 5'h02;
            3'h3: adcseq_ratio = 5'h04;
            3'h4: adcseq_ratio = 5'h06;
            3'h5: adcseq_ratio = 5'h0C;
            3'h6: adcseq_ratio = 5'h08;
            3'h7: adcseq_ratio = `ADCSEQ_MAX_DIV;
        endcase
    endfunction : adcseq_ratio

    // Nonzero prescaler code means converter clock allowed to run
    function automatic logic adcseq_pre_on(input logic [2:0] code);
        adcseq_pre_on = (code != `ADCSEQ_PRE_OFF);
    endfunction : adcseq_pre_on

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    adcseq_state_t s_q;
    adcseq_state_t s_d;
    logic [4:0] ratio;
    logic fall_en;
    logic [2:0] bit_idx;
    logic wr_pre_on;

    assign ratio = adcseq_ratio(s_q.ctrl.pre);
    // Ratio 1 toggles level every cycle; enable marks falling edge
    assign fall_en = adcseq_pre_on(s_q.ctrl.pre) && s_q.clk_lvl &&
        ((s_q.div + 5'h01 >= ratio) || (ratio == 5'h01));
    assign bit_idx = 3'h7 - s_q.cnt[2:0];
    // Prescaler field of the write data, decoded once
    assign wr_pre_on =
        adcseq_pre_on(i_ctrl_wdata[`ADCSEQ_PRE_HI:`ADCSEQ_PRE_LO]);

    // Next-state logic, phases advance on falling converter edge, divider every cycle
    always_comb begin
        s_d = s_q;
        // Divider runs whenever prescaler is nonzero and no halt is asserted
        if (adcseq_pre_on(s_q.ctrl.pre) && !i_halt_idle) begin
            if (ratio == 5'h01 || s_q.div + 5'h01 >= ratio) begin
                s_d.div = 5'h00;
                s_d.clk_lvl = ~s_q.clk_lvl;
            end else begin
                s_d.div = s_q.div + 5'h01;
            end
        end else begin
            s_d.div = 5'h00;
            s_d.clk_lvl = 1'b0;
        end
        // Halt outranks a resume and any phase step
        if (i_halt_idle) begin
            // Powered down; remember an interrupted run
            if (s_q.phase != ADCSEQ_OFF) begin
                s_d.run_pend = 1'b1;
            end
            s_d.phase = ADCSEQ_OFF;
        end else if (s_q.run_pend) begin
            // Interrupted run starts over from its reset phase
            s_d.run_pend = 1'b0;
            s_d.phase = ADCSEQ_RST;
            s_d.cnt = 4'h0;
        end else if (fall_en) begin
            // Phases step only on the falling converter edge
            unique case (s_q.phase)
                ADCSEQ_OFF: s_d.phase = ADCSEQ_OFF;
                ADCSEQ_RST, ADCSEQ_DESEL: begin
                    s_d.phase = ADCSEQ_SAMPLE;
                    s_d.cnt = 4'h0;
                    s_d.sar = 8'h80;
                end
                ADCSEQ_SAMPLE: begin
                    if (s_q.cnt == `ADCSEQ_SAMPLE_CYC - 4'h1) begin
                        s_d.phase = ADCSEQ_CONV;
                        s_d.cnt = 4'h0;
                    end else begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
                ADCSEQ_CONV: begin
                    // Keep or drop trial bit, then try the next one
                    if (!i_sar_cmp) begin
                        s_d.sar[bit_idx] = 1'b0;
                    end
                    if (bit_idx != 3'h0) begin
                        s_d.sar[bit_idx - 3'h1] = 1'b1;
                    end
                    if (s_q.cnt == `ADCSEQ_CONV_CYC - 4'h1) begin
                        s_d.phase = ADCSEQ_LOAD;
                        s_d.cnt = 4'h0;
                    end else begin
                        s_d.cnt = s_q.cnt + 4'h1;
                    end
                end
                ADCSEQ_LOAD: begin
                    // Result taken only when load ends, never mid-update
                    s_d.result = s_q.sar;
                    s_d.phase = s_q.ctrl.cont ? ADCSEQ_DESEL
                                              : ADCSEQ_OFF;
                end
            endcase
        end
        // Write wins over everything; abandons any running conversion
        if (i_ctrl_wr) begin
            s_d.ctrl.chan = i_ctrl_wdata[`ADCSEQ_CHAN_HI:`ADCSEQ_CHAN_LO];
            s_d.ctrl.diff = i_ctrl_wdata[`ADCSEQ_MODE_HI];
            s_d.ctrl.cont = i_ctrl_wdata[`ADCSEQ_MODE_LO];
            s_d.ctrl.pre = i_ctrl_wdata[`ADCSEQ_PRE_HI:`ADCSEQ_PRE_LO];
            s_d.cnt = 4'h0;
            s_d.div = 5'h00;
            s_d.clk_lvl = 1'b1;
            s_d.run_pend = 1'b0;
            if (!wr_pre_on || i_halt_idle) begin
                s_d.phase = ADCSEQ_OFF;
                s_d.clk_lvl = 1'b0;
                // A write during halt is held until the halt ends
                s_d.run_pend = i_halt_idle && wr_pre_on;
            end else begin
                s_d.phase = ADCSEQ_RST;
            end
        end
    end

    // Single register stage for all state
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            // Control field comes back cleared, converter powered down
            s_q <= '{ctrl: adcseq_ctrl_t'(`ADCSEQ_CTRL_RESET),
                     phase: ADCSEQ_OFF, cnt: 4'h0, div: 5'h00,
                     clk_lvl: 1'b0, result: 8'h00, sar: 8'h00,
                     run_pend: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Power rises combinationally with the write cycle itself;
    // a halted processor keeps the converter dark even then
    assign o_adc_power = (s_q.phase != ADCSEQ_OFF) ||
        (i_ctrl_wr && wr_pre_on && !i_halt_idle);
    assign o_adc_clk = s_q.clk_lvl;

    // Select drops for the whole deselect cycle between scans
    assign o_adc_select = (s_q.phase != ADCSEQ_OFF) &&
        (s_q.phase != ADCSEQ_DESEL);

    // Phase strobes straight from the registered phase, no glitches
    assign o_sample = (s_q.phase == ADCSEQ_SAMPLE);
    assign o_load = (s_q.phase == ADCSEQ_LOAD);

    // Result has no write path at all, so software cannot alter it
    assign o_conversion_result = s_q.result;

    // Readback in the same field order as it was written
    assign o_ctrl_rdata = {s_q.ctrl.chan, s_q.ctrl.diff, s_q.ctrl.cont,
                           s_q.ctrl.pre};

    // Input mux; neighbour pair is the channel with bit 0 flipped
    assign o_pos_chan = s_q.ctrl.chan;
    assign o_neg_chan = s_q.ctrl.chan ^ 3'h1;
    assign o_neg_ground = ~s_q.ctrl.diff;

    // Trial code to the DAC, straight from the register
    assign o_sar_code = s_q.sar;
endmodule : adcseq_core

//--- core/adcseq_regs.svh
// Register layout, reset values and timing counts of the converter sequencer
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH
`define ADCSEQ_CHAN_HI 7
`define ADCSEQ_CHAN_LO 5
`define ADCSEQ_MODE_HI 4
`define ADCSEQ_MODE_LO 3
`define ADCSEQ_PRE_HI 2
`define ADCSEQ_PRE_LO 0
`define ADCSEQ_CTRL_RESET 8'h00
`define ADCSEQ_PRE_OFF 3'h0
`define ADCSEQ_SAMPLE_CYC 4'h2
`define ADCSEQ_CONV_CYC 4'h8
`define ADCSEQ_MAX_DIV 5'h10
`endif

//--- core/adcseq_pkg.sv
// Types shared by the converter sequencer
package adcseq_pkg;
    typedef enum logic [2:0] {
        ADCSEQ_OFF, ADCSEQ_RST, ADCSEQ_SAMPLE, ADCSEQ_CONV, ADCSEQ_LOAD,
        ADCSEQ_DESEL
    } adcseq_phase_t;

    typedef struct packed {
        logic [2:0] chan;
        logic diff;
        logic cont;
        logic [2:0] pre;
    } adcseq_ctrl_t;

    typedef struct packed {
        adcseq_ctrl_t ctrl;
        adcseq_phase_t phase;
        logic [3:0] cnt;
        logic [4:0] div;
        logic clk_lvl;
        logic [7:0] result;
        logic [7:0] sar;
        logic run_pend;
    } adcseq_state_t;
endpackage : adcseq_pkg

//--- testbench/adcseq_core_monitor.sv
// Port checks for the converter sequencer
`timescale 1ns/1ps
module adcseq_core_monitor (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ctrl_wr,
    input wire logic [7:0] i_ctrl_wdata,
    input wire logic i_halt_idle,
    input wire logic [7:0] o_ctrl_rdata,
    input wire logic [7:0] o_conversion_result,
    input wire logic o_adc_power,
    input wire logic o_adc_select,
    input wire logic o_adc_clk,
    input wire logic o_sample,
    input wire logic o_load
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // Load ends with no write or halt in the way
    sequence s_load_end;
        o_load && !i_ctrl_wr && !i_halt_idle ##1 !o_load && !i_ctrl_wr;
    endsequence
    // Halt seen at two edges in a row
    sequence s_halted;
        (i_halt_idle && !i_ctrl_wr) [*2];
    endsequence
    a_power_up: assert property (i_ctrl_wr && !i_halt_idle
        && i_ctrl_wdata[2:0] != 3'h0 |-> o_adc_power)
        else $error("no power in write");
    a_clk_off: assert property (i_ctrl_wr && i_ctrl_wdata[2:0] == 3'h0
        |=> !o_adc_clk && !o_sample) else $error("clock runs");
    a_ctrl_back: assert property (i_ctrl_wr
        |=> o_ctrl_rdata == $past(i_ctrl_wdata)) else $error("readback");
    a_result_hold: assert property ($changed(o_conversion_result)
        |-> $past(o_load)) else $error("result moved");
    a_sample_sel: assert property (o_sample
        |-> o_adc_select && o_adc_power) else $error("sample off");
    a_load_order: assert property ($rose(o_load)
        |-> !$past(o_sample)) else $error("load after sample");
    a_halt_down: assert property (s_halted
        |-> !o_adc_power && !o_sample) else $error("power in halt");
    a_single_down: assert property (s_load_end ##0 !o_ctrl_rdata[3]
        |-> !o_adc_power) else $error("power after single");
    a_cont_desel: assert property (s_load_end ##0 o_ctrl_rdata[3]
        |-> !o_adc_select) else $error("no deselect");
endmodule : adcseq_core_monitor

bind adcseq_core adcseq_core_monitor i_mon (.*);

//--- testbench/testbench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module testbench;
    logic i_mclk = 0, i_reset = 1, i_ctrl_wr = 0, i_halt_idle = 0;
    logic i_sar_cmp = 0, pc = 0, ps = 0, pl = 0, o_neg_ground;
    logic [7:0] i_ctrl_wdata = 8'h00, v = 8'h00, o_ctrl_rdata;
    logic [7:0] o_conversion_result, o_sar_code;
    logic o_adc_power, o_adc_clk, o_adc_select, o_sample, o_load;
    logic [2:0] o_pos_chan, o_neg_chan;
    logic [12:0] q[$], e;
    logic [31:0] r;
    logic [4:0] dv[8] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h06, 5'h0C,
        5'h08, 5'h10};
    int err_total = 0, n_compared = 0, falls = 0, sf = 0, hr = 0;
    int hh = 0, done = 0, cyc = 0, seed = 32'hE6552194;
    adcseq_core i_adcseq_core (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_ctrl_wr(i_ctrl_wr),
        .i_ctrl_wdata(i_ctrl_wdata), .i_halt_idle(i_halt_idle),
        .i_sar_cmp(i_sar_cmp), .o_ctrl_rdata(o_ctrl_rdata),
        .o_conversion_result(o_conversion_result),
        .o_adc_power(o_adc_power), .o_adc_clk(o_adc_clk),
        .o_adc_select(o_adc_select), .o_sample(o_sample),
        .o_load(o_load), .o_pos_chan(o_pos_chan),
        .o_neg_chan(o_neg_chan), .o_neg_ground(o_neg_ground),
        .o_sar_code(o_sar_code)
    );
    task chk(input string n, input logic [15:0] s, x);
        n_compared++;
        if (s !== x) begin
            err_total++;
            $display("wrong value %s exp %h seen %h", n, x, s);
        end
    endtask : chk
    task wrap_up;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    // Control write; fall counters restart with it
    task wr(input logic [7:0] w);
        @(posedge i_mclk);
        i_ctrl_wr <= 1'b1;
        i_ctrl_wdata <= w;
        falls = 0;
        sf = 0;
        @(posedge i_mclk);
        i_ctrl_wr <= 1'b0;
        @(negedge i_mclk);
        chk("gnd", o_neg_ground, !w[4]);
        chk("pos", o_pos_chan, w[7:5]);
        if (w[4]) chk("neg", o_neg_chan, w[7:5] ^ 3'h1);
    endtask : wr
    task waitc(input int n);
        int d;
        d = done + n;
        for (int k = 0; k < 2000 && done < d; k++) @(posedge i_mclk);
        chk("done", 16'(done), 16'(d));
    endtask : waitc
    initial forever #20 i_mclk = ~i_mclk;
    // Comparator answers from a random analog level
    always @(posedge i_mclk) begin
        i_sar_cmp <= (o_sar_code <= v);
        cyc++;
        if (cyc > 30000) begin
            err_total++;
            wrap_up();
        end
    end
    // Count converter clock falls; settle each result off the queue
    always @(negedge i_mclk) begin
        if (o_adc_clk === 1'b1) hr++;
        else if (pc) begin
            hh = hr;
            hr = 0;
            falls++;
            if (ps) sf++;
        end
        if (pl && o_load === 1'b0) begin
            e = q.size() ? q.pop_front() : 13'h1FFF;
            chk("result", o_conversion_result, e[7:0]);
            chk("falls", 16'(falls), 16'h000C);
            chk("sample", 16'(sf), 16'h0002);
            chk("half", 16'(hh), e[12:8]);
            falls = 0;
            sf = 0;
            done++;
        end
        pc = o_adc_clk;
        ps = o_sample;
        pl = o_load;
    end
    initial begin
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        // Each prescaler, all four mode codes among them
        for (logic [3:0] p = 4'h1; p < 4'h8; p++) begin
            r = $random(seed);
            v = r[15:8];
            q.push_back({dv[p], v});
            if (p[0]) q.push_back({dv[p], v});
            wr({r[7:5], p[1], p[0], p[2:0]});
            waitc(p[0] ? 2 : 1);
            if (!p[0]) chk("pd", o_adc_power, 1'b0);
            wr(8'h00);
            repeat (40) @(posedge i_mclk);
            @(negedge i_mclk);
            chk("off", {o_adc_power, o_adc_clk}, 16'h0000);
        end
        // A second write abandons the slow first conversion; both
        // prescalers keep the converter clock inside its range
        r = $random(seed);
        v = r[15:8];
        q.push_back({dv[6], v});
        wr(8'h45);
        wr(8'hB6);
        waitc(1);
        repeat (300) @(posedge i_mclk);
        // Halt mid-run, then the run starts over
        r = $random(seed);
        v = r[15:8];
        q.push_back({dv[7], v});
        wr(8'h27);
        repeat (10) @(posedge i_mclk);
        i_halt_idle <= 1'b1;
        repeat (20) @(posedge i_mclk);
        @(negedge i_mclk);
        chk("halt", {o_adc_power, o_adc_clk}, 16'h0000);
        @(posedge i_mclk);
        i_halt_idle <= 1'b0;
        falls = 0;
        sf = 0;
        waitc(1);
        // Reset during a continuous run clears both registers
        wr(8'h2F);
        repeat (30) @(posedge i_mclk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(negedge i_mclk);
        chk("rst", {o_conversion_result, o_ctrl_rdata}, 16'h0000);
        chk("rstp", {o_adc_power, o_adc_clk, o_sample}, 16'h0000);
        wrap_up();
    end
endmodule : testbench
